// ==== eeprom_status_regs.svh ====
// Opcodes, field codes and timing constants of the serial EEPROM status and protect block
// Function
// RQ1 - Status read answered anytime, even while busy
// RQ2 - Status byte: enable7, protect3..2, latch1, busy0
// RQ3 - Busy flag shows internal write; read-only
// RQ4 - Latch flag mirrors latch; clear blocks writes
// RQ5 - Latch commands work regardless of protection
// RQ6 - Protect bits nonvolatile, changed by status write
// RQ7 - Four sectors: none, top quarter, half, all
// RQ8 - Protected ranges aligned to address top
// RQ9 - Hardware protect enable bit for larger densities
// RQ10 - Hardware protect when pin low and enable set
// RQ11 - Hardware protect blocks only nonvolatile status bits
// RQ12 - Smallest densities lack the enable bit
// RQ13 - Completed write clears latch automatically
// RQ14 - Write starts only on aligned select rise
// RQ15 - Array commands ignored during internal write
// RQ16 - Latch cleared at power-up
// RQ17 - Standby, output off until select falls
// RQ18 - Page erase sets addressed page to FFh
// RQ19 - Host sets latch in separate transaction first
// RQ20 - Erase opcode plus address selects whole page
// RQ21 - Erase starts on aligned rise; busy meanwhile
// RQ22 - Erase into protected region is aborted
// RQ23 - Small densities: protect pin low clears latch
// RQ24 - Output bits change after serial clock fall
// RQ25 - Status byte MSB first, repeated until deselect
// RQ26 - Accepted status write changes writable bits only
`ifndef EEPROM_STATUS_REGS_SVH
`define EEPROM_STATUS_REGS_SVH

`define OPC_STATUS_WRITE 8'h01
`define OPC_ARRAY_WRITE 8'h02
`define OPC_LATCH_CLEAR 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_LATCH_SET 8'h06
`define OPC_PAGE_ERASE 8'h42

`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3
`define SECTOR_TOP 2'h3

`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define NV_INIT 3'h0
`define DONT_CARE_READ 3'h0

`define CLK_PERIOD_NS 40
`define WRITE_CYCLE_NS 5000000

`endif

// ==== eeprom_status_pkg.sv ====
// Types shared by the serial EEPROM status and protect block
package eeprom_status_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_DATA,
		ST_TAIL,
		ST_STATUS_OUT,
		ST_IGNORE
	} xfer_state_t;

	typedef struct packed {
		logic hwProtectEnable;
		logic [2:0] dontCare;
		logic blockProtectHigh;
		logic blockProtectLow;
		logic writeLatchFlag;
		logic writeInProgressFlag;
	} status_t;

	typedef struct packed {
		logic valid;
		logic erase;
		logic [23:0] addr;
	} array_req_t;

endpackage : eeprom_status_pkg

// ==== spi_eeprom_status_protect.sv ====
// Status register, write protection and page erase control of an SPI EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_status_regs.svh"

module spi_eeprom_status_protect
	import eeprom_status_pkg::*;
#(
	parameter int ADDR_BITS = 16,
	parameter int ADDR_BYTES = 2,
	parameter bit HAS_HW_PROTECT_EN = 1'b1,
	parameter bit HAS_PAGE_ERASE = 1'b1,
	parameter bit WP_CLEARS_LATCH = 1'b0,
	parameter int WRITE_CYCLES = `WRITE_CYCLE_NS / `CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic csN,
	input wire logic sck,
	input wire logic si,
	input wire logic wpN,
	output logic soOut,
	output logic soOe,
	output logic writeBusy,
	output array_req_t arrayReq
);

	localparam int CW = $clog2(WRITE_CYCLES + 1);
	localparam int AW = ADDR_BYTES * 8;
	localparam logic [9:0] CNT_ONE = 10'h001;
	localparam logic [9:0] CNT_STATUS = 10'h002;
	localparam logic [9:0] CNT_ERASE = 10'(ADDR_BYTES + 1);
	localparam logic [9:0] CNT_WRITE = 10'(ADDR_BYTES + 2);
	localparam logic [9:0] CNT_ADDR = 10'(ADDR_BYTES);
	localparam logic [CW-1:0] CYC_LOAD = CW'(WRITE_CYCLES);
	localparam logic [CW-1:0] CYC_LAST = CW'(1);

	// Pin synchronisers; first stages are read only by second stages
	logic csS1_q, csS2_q, csPrev_q;
	logic sckS1_q, sckS2_q, sckPrev_q;
	logic siS1_q, siS2_q;
	logic wpS1_q, wpS2_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			csS1_q <= 1'b1;
			csS2_q <= 1'b1;
			csPrev_q <= 1'b1;
			sckS1_q <= 1'b0;
			sckS2_q <= 1'b0;
			sckPrev_q <= 1'b0;
			siS1_q <= 1'b0;
			siS2_q <= 1'b0;
			wpS1_q <= 1'b1;
			wpS2_q <= 1'b1;
		end else begin
			csS1_q <= csN;
			csS2_q <= csS1_q;
			csPrev_q <= csS2_q;
			sckS1_q <= sck;
			sckS2_q <= sckS1_q;
			sckPrev_q <= sckS2_q;
			siS1_q <= si;
			siS2_q <= siS1_q;
			wpS1_q <= wpN;
			wpS2_q <= wpS1_q;
		end
	end

	// Idle high select after reset means only a real falling edge opens a frame
	logic csFall, csRise, sckRise, sckFall;
	assign csFall = csPrev_q & ~csS2_q; // [RQ17]
	assign csRise = ~csPrev_q & csS2_q;
	assign sckRise = ~sckPrev_q & sckS2_q & ~csS2_q;
	assign sckFall = sckPrev_q & ~sckS2_q & ~csS2_q;

	xfer_state_t state_q;
	logic [7:0] shiftIn_q, opcode_q, data_q;
	logic [2:0] bitCnt_q, outIdx_q;
	logic [9:0] byteCnt_q;
	logic [AW-1:0] addr_q;
	logic [7:0] byteNext;
	logic [CW-1:0] cycleCnt_q;
	logic busy_q, latch_q;
	logic [2:0] nv_q = `NV_INIT; // Nonvolatile: survives reset_n on purpose
	status_t statusNow;

	assign byteNext = {shiftIn_q[6:0], siS2_q};
	assign writeBusy = busy_q;

	always_comb begin
		statusNow.hwProtectEnable = HAS_HW_PROTECT_EN ? nv_q[2] : 1'b0; // [RQ12]
		statusNow.dontCare = `DONT_CARE_READ;
		statusNow.blockProtectHigh = nv_q[1];
		statusNow.blockProtectLow = nv_q[0];
		statusNow.writeLatchFlag = latch_q; // [RQ4]
		statusNow.writeInProgressFlag = busy_q; // [RQ3]
	end

	function automatic xfer_state_t decodeOp(input logic [7:0] op, input logic busy);
		xfer_state_t nxt;
		nxt = ST_IGNORE;
		if (op == `OPC_STATUS_READ) begin
			nxt = ST_STATUS_OUT; // [RQ1]
		end else if (busy) begin
			nxt = ST_IGNORE; // [RQ15]
		end else if (op == `OPC_ARRAY_WRITE || (HAS_PAGE_ERASE && op == `OPC_PAGE_ERASE)) begin
			nxt = ST_ADDR;
		end else if (op == `OPC_STATUS_WRITE) begin
			nxt = ST_DATA;
		end else if (op == `OPC_LATCH_SET || op == `OPC_LATCH_CLEAR) begin
			nxt = ST_TAIL;
		end
		return nxt;
	endfunction : decodeOp

	// Serial receive, mode 0: sample on rising clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			shiftIn_q <= 8'h00;
			opcode_q <= 8'h00;
			data_q <= 8'h00;
			bitCnt_q <= `BIT_FIRST;
			byteCnt_q <= 10'h000;
			addr_q <= '0;
		end else if (csFall) begin
			state_q <= ST_OPCODE;
			bitCnt_q <= `BIT_FIRST;
			byteCnt_q <= 10'h000;
		end else if (csRise) begin
			state_q <= ST_IDLE;
		end else if (sckRise && state_q != ST_IDLE) begin
			shiftIn_q <= byteNext;
			bitCnt_q <= bitCnt_q + 3'h1;
			if (bitCnt_q == `BIT_LAST) begin
				if (byteCnt_q != 10'h3FF) begin
					byteCnt_q <= byteCnt_q + CNT_ONE;
				end
				unique case (state_q)
					ST_OPCODE: begin
						opcode_q <= byteNext;
						state_q <= decodeOp(byteNext, busy_q);
					end
					ST_ADDR: begin
						addr_q <= {addr_q[AW-9:0], byteNext};
						if (byteCnt_q == CNT_ADDR) begin
							state_q <= (opcode_q == `OPC_PAGE_ERASE) ? ST_TAIL : ST_DATA; // [RQ20]
						end
					end
					ST_DATA: data_q <= byteNext;
					ST_TAIL, ST_STATUS_OUT, ST_IGNORE, ST_IDLE: state_q <= state_q;
				endcase
			end
		end
	end

	// Command qualification at the rising select edge
	logic aligned, latchCmdOk, statusWriteOk, arrayWriteOk, eraseOk;
	logic addrProtected, hwProtected, startArray, startStatus, writeDone;
	logic [1:0] sector;

	assign aligned = (bitCnt_q == `BIT_FIRST); // [RQ14]
	assign latchCmdOk = state_q == ST_TAIL && aligned && byteCnt_q == CNT_ONE
		&& (opcode_q == `OPC_LATCH_SET || opcode_q == `OPC_LATCH_CLEAR);
	assign statusWriteOk = state_q == ST_DATA && aligned && byteCnt_q == CNT_STATUS
		&& opcode_q == `OPC_STATUS_WRITE;
	assign arrayWriteOk = state_q == ST_DATA && aligned && byteCnt_q >= CNT_WRITE
		&& opcode_q == `OPC_ARRAY_WRITE;
	assign eraseOk = state_q == ST_TAIL && aligned && byteCnt_q == CNT_ERASE
		&& opcode_q == `OPC_PAGE_ERASE; // [RQ21]
	assign sector = addr_q[ADDR_BITS-1 -: 2]; // [RQ8]

	always_comb begin
		unique case (nv_q[1:0])
			`BP_NONE: addrProtected = 1'b0; // [RQ7]
			`BP_QUARTER: addrProtected = (sector == `SECTOR_TOP);
			`BP_HALF: addrProtected = sector[1];
			`BP_ALL: addrProtected = 1'b1;
		endcase
	end

	assign hwProtected = HAS_HW_PROTECT_EN && nv_q[2] && !wpS2_q; // [RQ9] [RQ10]
	assign startArray = csRise && latch_q && (arrayWriteOk || eraseOk) && !addrProtected; // [RQ22] [RQ4]
	assign startStatus = csRise && latch_q && statusWriteOk && !hwProtected; // [RQ11]
	assign writeDone = busy_q && cycleCnt_q == CYC_LAST;

	// Self-timed cycle; CS state no longer matters once started
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cycleCnt_q <= '0;
			busy_q <= 1'b0;
		end else if (startArray || startStatus) begin
			cycleCnt_q <= CYC_LOAD;
			busy_q <= 1'b1; // [RQ3] [RQ21]
		end else if (busy_q) begin
			cycleCnt_q <= cycleCnt_q - CYC_LAST;
			busy_q <= !writeDone;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_q <= 1'b0; // [RQ16]
		end else if (writeDone) begin
			latch_q <= 1'b0; // [RQ13]
		end else if (WP_CLEARS_LATCH && !wpS2_q) begin
			latch_q <= 1'b0; // [RQ23]
		end else if (csRise && latchCmdOk) begin
			latch_q <= (opcode_q == `OPC_LATCH_SET); // [RQ5]
		end
	end

	// No reset: these bits model nonvolatile cells
	always_ff @(posedge clk) begin
		if (startStatus) begin
			nv_q[2] <= HAS_HW_PROTECT_EN ? data_q[7] : 1'b0; // [RQ26] [RQ6]
			nv_q[1:0] <= data_q[3:2];
		end
	end

	// Array engine request; erase means fill the whole page with FFh
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arrayReq <= '0;
		end else begin
			arrayReq.valid <= startArray; // [RQ18]
			if (startArray) begin
				arrayReq.erase <= (opcode_q == `OPC_PAGE_ERASE);
				arrayReq.addr <= 24'(addr_q[ADDR_BITS-1:0]);
			end
		end
	end

	// Serial transmit: change after falling clock, MSB first, wraps until deselect
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			soOut <= 1'b0;
			soOe <= 1'b0;
			outIdx_q <= `BIT_LAST;
		end else if (csFall || csRise) begin
			soOe <= 1'b0; // [RQ17]
			outIdx_q <= `BIT_LAST;
		end else if (sckFall && state_q == ST_STATUS_OUT) begin
			soOe <= 1'b1;
			soOut <= statusNow[outIdx_q]; // [RQ24] [RQ25] [RQ2]
			outIdx_q <= outIdx_q - 3'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_started;
		(startArray || startStatus) ##1 busy_q;
	endsequence

	property p_busyHolds;
		s_started |-> busy_q [*8];
	endproperty
	a_busyHolds: assert property (p_busyHolds) else $error("busy dropped early"); // [RQ3]

	property p_latchDone;
		writeDone |=> !latch_q && !busy_q;
	endproperty
	a_latchDone: assert property (p_latchDone) else $error("latch kept after write"); // [RQ13]

	property p_hwBlocks;
		(csRise && statusWriteOk && hwProtected) |=> $stable(nv_q) && !busy_q;
	endproperty
	a_hwBlocks: assert property (p_hwBlocks) else $error("protected status changed"); // [RQ11]

	property p_protErase;
		(csRise && eraseOk && addrProtected) |=> !arrayReq.valid;
	endproperty
	a_protErase: assert property (p_protErase) else $error("protected erase started"); // [RQ22]

	property p_latchSet;
		(csRise && latchCmdOk && opcode_q == `OPC_LATCH_SET && !writeDone && !(WP_CLEARS_LATCH && !wpS2_q)) |=> latch_q;
	endproperty
	a_latchSet: assert property (p_latchSet) else $error("latch not set"); // [RQ5]

	property p_unaligned;
		(csRise && !aligned) |=> !arrayReq.valid && $stable(nv_q);
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("write on unaligned deselect"); // [RQ14]

	property p_hiZ;
		csRise |=> !soOe [*2];
	endproperty
	a_hiZ: assert property (p_hiZ) else $error("output driven while deselected"); // [RQ17]

	property p_msbFirst;
		(sckFall && state_q == ST_STATUS_OUT && outIdx_q == `BIT_LAST && !csRise) |=>
			soOe && soOut == $past(statusNow.hwProtectEnable);
	endproperty
	a_msbFirst: assert property (p_msbFirst) else $error("status bit 7 not first"); // [RQ25]

	property p_reqBusy;
		arrayReq.valid |-> busy_q ##1 !arrayReq.valid;
	endproperty
	a_reqBusy: assert property (p_reqBusy) else $error("request without busy"); // [RQ21]

	property p_wpLatch;
		(WP_CLEARS_LATCH && !wpS2_q) |=> !latch_q;
	endproperty
	a_wpLatch: assert property (p_wpLatch) else $error("latch held with pin low"); // [RQ23]

	sequence s_opcodeDone;
		sckRise && !csFall && state_q == ST_OPCODE && bitCnt_q == `BIT_LAST;
	endsequence

	// Status read must decode even in the middle of a busy cycle
	property p_statusAnytime;
		(s_opcodeDone ##0 (byteNext == `OPC_STATUS_READ)) |=> state_q == ST_STATUS_OUT;
	endproperty
	a_statusAnytime: assert property (p_statusAnytime) else $error("status read not decoded"); // [RQ1]

	property p_busyIgnore;
		(s_opcodeDone ##0 (busy_q && byteNext != `OPC_STATUS_READ)) |=> state_q == ST_IGNORE;
	endproperty
	a_busyIgnore: assert property (p_busyIgnore) else $error("command taken while busy"); // [RQ15]

	property p_latchClear;
		(csRise && latchCmdOk && opcode_q == `OPC_LATCH_CLEAR) |=> !latch_q;
	endproperty
	a_latchClear: assert property (p_latchClear) else $error("latch not cleared"); // [RQ5]

	property p_noLatch;
		(csRise && !latch_q) |=> !arrayReq.valid && $stable(nv_q);
	endproperty
	a_noLatch: assert property (p_noLatch) else $error("write started without latch"); // [RQ4]

	property p_nvWrite;
		startStatus |=> busy_q && nv_q[1:0] == $past(data_q[3:2])
			&& nv_q[2] == (HAS_HW_PROTECT_EN && $past(data_q[7]));
	endproperty
	a_nvWrite: assert property (p_nvWrite) else $error("status write value wrong"); // [RQ26]

	property p_eraseReq;
		(startArray && opcode_q == `OPC_PAGE_ERASE) |=> arrayReq.valid && arrayReq.erase
			&& arrayReq.addr == 24'($past(addr_q[ADDR_BITS-1:0]));
	endproperty
	a_eraseReq: assert property (p_eraseReq) else $error("erase request wrong"); // [RQ18]

endmodule : spi_eeprom_status_protect

`default_nettype wire

// ==== spi_host_model.sv ====
// SPI host model that frames commands on the link of the status and protect block
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input wire logic clk,
	output logic csN,
	output logic sck,
	output logic si,
	input wire logic soOut,
	input wire logic soOe
);
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end

	// Mode 0 frame, MSB first, 320 ns link period; reply sampled mid-high
	task automatic xfer(input int nBits, input logic [39:0] txd, output logic [39:0] rxd);
		rxd = '0;
		@(negedge clk);
		csN = 1'b0;
		for (int i = nBits - 1; i >= 0; i--) begin
			si = txd[i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (2) @(negedge clk);
			rxd = {rxd[38:0], soOe ? soOut : 1'bx};
			repeat (2) @(negedge clk);
			sck = 1'b0;
		end
		repeat (4) @(negedge clk);
		// Deselect right after the last bit counted by the caller
		csN = 1'b1;
		// Released data line must not keep its last level
		si = ~si;
		repeat (6) @(negedge clk);
	endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ==== spi_eeprom_status_protect_bench.sv ====
// Self-checking bench of the serial EEPROM status and protect block
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_status_protect_bench;
	import eeprom_status_pkg::*;
	localparam int WCYC = 200;
	logic clk, resetN, wpN, csN, sck, si, soOut, soOe, writeBusy;
	array_req_t arrayReq, lastReq;
	int nErrors, nCompared, nReq;
	logic [15:0] addrs [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF};

	spi_eeprom_status_protect #(.WRITE_CYCLES(WCYC)) spi_eeprom_status_protect_inst (.clk(clk),
		.reset_n(resetN), .csN(csN), .sck(sck), .si(si), .wpN(wpN), .soOut(soOut), .soOe(soOe),
		.writeBusy(writeBusy), .arrayReq(arrayReq));
	spi_host_model spi_host_model_inst (.clk(clk), .csN(csN), .sck(sck), .si(si), .soOut(soOut),
		.soOe(soOe));

	initial clk = 1'b0;
	always #20 clk = ~clk;
	always @(negedge clk) if (arrayReq.valid === 1'b1) begin
		nReq++;
		lastReq = arrayReq;
	end

	task automatic closeOut();
		$display("errors %0d compared %0d", nErrors, nCompared);
		if (nErrors == 0 && nCompared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : closeOut

	task automatic check(input string what, input logic [31:0] expV, input logic [31:0] gotV);
		nCompared++;
		if (gotV !== expV) begin
			nErrors++;
			$display("unexpected %s expected %h seen %h", what, expV, gotV);
		end
	endtask : check

	task automatic send(input int n, input logic [39:0] d);
		logic [39:0] r;
		spi_host_model_inst.xfer(n, d, r);
	endtask : send

	task automatic readStatus(input logic [7:0] expV);
		logic [39:0] r;
		spi_host_model_inst.xfer(16, 40'h0500, r);
		check("status", expV, r[7:0]);
		check("released output", 0, soOe);
	endtask : readStatus

	task automatic waitIdle();
		for (int k = 0; writeBusy !== 1'b0; k++) begin
			@(negedge clk);
			if (k > WCYC + 100) begin
				nErrors++;
				closeOut();
			end
		end
	endtask : waitIdle

	task automatic writeStatus(input logic [7:0] v);
		send(8, 40'h06);
		send(16, {24'h0, 8'h01, v});
		check("status write busy", 1, writeBusy);
		waitIdle();
	endtask : writeStatus

	task automatic erase(input logic [15:0] a, input logic ok, input logic [7:0] st);
		int n0;
		n0 = nReq;
		send(8, 40'h06);
		send(24, {16'h0, 8'h42, a});
		check("erase busy", ok, writeBusy);
		check("erase count", ok, nReq - n0);
		if (ok) check("erase req", {1'b1, 8'h00, a}, {lastReq.erase, lastReq.addr});
		waitIdle();
		readStatus(ok ? st : st | 8'h02);
		send(8, 40'h04);
	endtask : erase

	task automatic scReset();
		check("idle outputs", 0, {soOe, writeBusy, arrayReq.valid});
		readStatus(8'h00);
		send(8, 40'h06);
		readStatus(8'h02);
		send(8, 40'h04);
		readStatus(8'h00);
	endtask : scReset

	task automatic scStatusWrite();
		send(8, 40'h06);
		send(16, 40'h01FC);
		readStatus(8'h8F);
		waitIdle();
		readStatus(8'h8C);
		@(negedge clk) resetN = 1'b0;
		repeat (3) @(negedge clk);
		resetN = 1'b1;
		repeat (3) @(negedge clk);
		readStatus(8'h8C);
	endtask : scStatusWrite

	task automatic scHwProtect();
		writeStatus(8'h84);
		wpN = 1'b0;
		send(8, 40'h06);
		readStatus(8'h86);
		send(16, 40'h0100);
		check("protected write busy", 0, writeBusy);
		readStatus(8'h86);
		send(8, 40'h04);
		erase(16'h1234, 1'b1, 8'h84);
		erase(16'hC000, 1'b0, 8'h84);
		wpN = 1'b1;
		writeStatus(8'h00);
		readStatus(8'h00);
	endtask : scHwProtect

	task automatic scBlockTable();
		logic ok;
		for (int bp = 0; bp < 4; bp++) begin
			writeStatus(8'(bp << 2));
			foreach (addrs[i]) begin
				ok = bp == 0 || (bp == 1 && addrs[i] < 16'hC000) || (bp == 2 && addrs[i] < 16'h8000);
				erase(addrs[i], ok, 8'(bp << 2));
			end
		end
		writeStatus(8'h00);
	endtask : scBlockTable

	task automatic scRefusals();
		int n0;
		n0 = nReq;
		send(24, 40'h42_0100);
		check("no latch erase", 0, writeBusy);
		send(8, 40'h06);
		send(23, 40'h21_0080);
		check("short erase", 0, {writeBusy, 8'(nReq - n0)});
		readStatus(8'h02);
		send(24, 40'h42_0100);
		send(8, 40'h06);
		send(24, 40'h42_0200);
		check("busy ignore", 1, nReq - n0);
		waitIdle();
		readStatus(8'h00);
	endtask : scRefusals

	task automatic scArrayWrite();
		int n0;
		n0 = nReq;
		send(8, 40'h06);
		send(40, 40'h02_0123_5AA5);
		check("write busy", 1, writeBusy);
		check("write count", 1, nReq - n0);
		check("write req", {1'b0, 8'h00, 16'h0123}, {lastReq.erase, lastReq.addr});
		waitIdle();
		readStatus(8'h00);
		writeStatus(8'h04);
		send(8, 40'h06);
		send(32, 40'h02FF_005A);
		check("protected write", 0, {writeBusy, 8'(nReq - n0 - 1)});
		readStatus(8'h06);
		send(8, 40'h04);
		writeStatus(8'h00);
	endtask : scArrayWrite

	initial begin
		resetN = 1'b0;
		wpN = 1'b1;
		nErrors = 0;
		nCompared = 0;
		nReq = 0;
		repeat (5) @(negedge clk);
		resetN = 1'b1;
		repeat (3) @(negedge clk);
		scReset();
		scStatusWrite();
		scHwProtect();
		scBlockTable();
		scArrayWrite();
		scRefusals();
		closeOut();
	end
endmodule : spi_eeprom_status_protect_bench

`default_nettype wire
